//--- core/bss_pkg.sv
/*
  Constants, timing figures and state encoding of the buck start-up sequencer.
  Assumes a single 200 MHz system clock.
*/
package bss_pkg;
  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  // ----------------------------------------------------------------
  // Timing figures in their own unit, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int BIAS_DELAY_US = 6800;
  localparam int BIAS_DELAY_CYC = (BIAS_DELAY_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int SOFT_START_US = 6800;
  localparam int SOFT_START_CYC = (SOFT_START_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int SAMPLE_MAX_US = 3400;
  localparam int SAMPLE_MAX_CYC = (SAMPLE_MAX_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int RAMP_STEPS = 64;
  localparam int STEP_CYC = SOFT_START_CYC / RAMP_STEPS;
  localparam int EA_INIT_STEPS = 2;
  // ----------------------------------------------------------------
  // Widths, reset values and ramp limit
  // ----------------------------------------------------------------
  localparam int SET_W = 8;
  localparam int RAMP_W = 7;
  localparam logic [7:0] SET_RST = 8'h00;
  localparam logic [6:0] RAMP_RST = 7'h00;
  localparam logic [6:0] RAMP_FINAL = 7'h40;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_EN = 3'b001,
    ST_BIAS_DLY = 3'b010,
    ST_SAMPLE = 3'b011,
    ST_SOFT = 3'b100,
    ST_RUN = 3'b101
  } bss_state_e;
endpackage : bss_pkg

//--- core/bss_timer.sv
/*
  Down-counting interval timer with load and done pulse.
  Assumes the caller loads it and holds run while it counts.
*/
`timescale 1ns/1ps
module bss_timer #(
  parameter int WIDTH = 24
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  input wire logic run,
  output logic done
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge clk_sys)
  begin
    if (srst || load)
    begin
      count <= srst ? '0 : loadValue;
    end
    else if (run && count != '0)
    begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || load)
    begin
      done <= 1'b0;
    end
    else
    begin
      done <= run && (count == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
endmodule : bss_timer

//--- core/bss_sequencer.sv
/*
  Start-up sequencer of a step-down converter: enable wait, bias delay,
  overcurrent set-point sample and hold, 65-step soft-start, pre-bias gating.
  Assumes all inputs are synchronous to clk_sys; analog comparisons arrive
  as levels (por, enable trip, sampler done, ramp-above-output).
*/
`timescale 1ns/1ps
module bss_sequencer #(
  parameter int BIAS_DELAY_CYCLES = bss_pkg::BIAS_DELAY_CYC,
  parameter int SAMPLE_MAX_CYCLES = bss_pkg::SAMPLE_MAX_CYC,
  parameter int STEP_CYCLES = bss_pkg::STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic porGood,
  input wire logic enableAboveTrip,
  input wire logic sampleCmpHigh,
  input wire logic rampAboveOutput,
  input wire logic retryRequest,
  output logic enablePullupOn,
  output logic setCurrentOn,
  output logic lowSideAllowed,
  output logic highSideAllowed,
  output logic oscillatorRun,
  output logic errAmpEnable,
  output logic [bss_pkg::SET_W-1:0] setPoint,
  output logic setPointValid,
  output logic [bss_pkg::RAMP_W-1:0] rampValue,
  output logic softStartDone,
  output bss_pkg::bss_state_e stateOut
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int TW = 24;
  localparam int RW = bss_pkg::RAMP_W;
  bss_pkg::bss_state_e state;
  bss_pkg::bss_state_e next_state;
  logic timerLoad;
  logic [TW-1:0] timerValue;
  logic timerRun;
  logic timerDone;
  logic [TW-1:0] sampleCount;
  logic [TW-1:0] stepCount;
  logic stepTick;
  logic switchesReleased;
  logic rampFull;

  function automatic logic [TW-1:0] cyc(input int n);
    cyc = TW'(n);
  endfunction : cyc

  // ----------------------------------------------------------------
  // Interval timer for bias delay
  // ----------------------------------------------------------------
  bss_timer #(
    .WIDTH(TW)
  ) uTimer (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(timerLoad),
    .loadValue(timerValue),
    .run(timerRun),
    .done(timerDone)
  );

  assign timerValue = cyc(BIAS_DELAY_CYCLES);
  assign timerLoad = (state == bss_pkg::ST_WAIT_EN) && enableAboveTrip;
  assign timerRun = (state == bss_pkg::ST_BIAS_DLY);
  assign rampFull = (rampValue > bss_pkg::RAMP_FINAL);

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      bss_pkg::ST_IDLE:
      begin
        if (porGood)
        begin
          next_state = bss_pkg::ST_WAIT_EN;
        end
      end
      bss_pkg::ST_WAIT_EN:
      begin
        if (enableAboveTrip)
        begin
          next_state = bss_pkg::ST_BIAS_DLY;
        end
      end
      bss_pkg::ST_BIAS_DLY:
      begin
        if (timerDone)
        begin
          next_state = bss_pkg::ST_SAMPLE;
        end
      end
      bss_pkg::ST_SAMPLE:
      begin
        // Comparator high means the DAC has reached the pin voltage
        if (sampleCmpHigh || sampleCount >= cyc(SAMPLE_MAX_CYCLES))
        begin
          next_state = bss_pkg::ST_SOFT;
        end
      end
      bss_pkg::ST_SOFT:
      begin
        if (rampFull)
        begin
          next_state = bss_pkg::ST_RUN;
        end
      end
      bss_pkg::ST_RUN:
      begin
        if (retryRequest)
        begin
          next_state = bss_pkg::ST_SOFT;
        end
      end
      default:
      begin
        next_state = bss_pkg::ST_IDLE;
      end
    endcase
    // Disable anywhere after enable wait restarts the whole sequence
    if (state != bss_pkg::ST_IDLE && state != bss_pkg::ST_WAIT_EN && !enableAboveTrip)
    begin
      next_state = bss_pkg::ST_WAIT_EN;
    end
    if (!porGood)
    begin
      next_state = bss_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state <= bss_pkg::ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Set-point sample and hold
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst || state != bss_pkg::ST_SAMPLE)
    begin
      sampleCount <= '0;
    end
    else
    begin
      sampleCount <= sampleCount + 1'b1;
    end
  end

  // Counter stays put from sampling until bias loss or the next bias delay, so the hold never decays
  always_ff @(posedge clk_sys)
  begin
    if (srst || !porGood || state == bss_pkg::ST_BIAS_DLY)
    begin
      setPoint <= bss_pkg::SET_RST;
    end
    else if (state == bss_pkg::ST_SAMPLE && next_state == bss_pkg::ST_SAMPLE
             && setPoint != {bss_pkg::SET_W{1'b1}})
    begin
      setPoint <= setPoint + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || !porGood || state == bss_pkg::ST_BIAS_DLY)
    begin
      setPointValid <= 1'b0;
    end
    else if (state == bss_pkg::ST_SAMPLE && next_state == bss_pkg::ST_SOFT)
    begin
      setPointValid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Soft-start ramp
  // ----------------------------------------------------------------
  // Step period is a constant; no input touches the rate
  always_ff @(posedge clk_sys)
  begin
    if (srst || state != bss_pkg::ST_SOFT || stepTick)
    begin
      stepCount <= '0;
    end
    else
    begin
      stepCount <= stepCount + 1'b1;
    end
  end

  assign stepTick = (state == bss_pkg::ST_SOFT) && (stepCount == cyc(STEP_CYCLES - 1));

  // Main input supply is not watched; only enable or bias loss cuts the ramp short
  always_ff @(posedge clk_sys)
  begin
    if (srst || (state != bss_pkg::ST_SOFT && state != bss_pkg::ST_RUN))
    begin
      rampValue <= bss_pkg::RAMP_RST;
    end
    else if (state == bss_pkg::ST_RUN && retryRequest)
    begin
      rampValue <= bss_pkg::RAMP_RST;
    end
    else if (stepTick && !rampFull)
    begin
      rampValue <= rampValue + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      softStartDone <= 1'b0;
    end
    else
    begin
      softStartDone <= (state == bss_pkg::ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Switch gating and pin controls
  // ----------------------------------------------------------------
  // Pre-bias latch: once the ramp passes the output it stays released
  always_ff @(posedge clk_sys)
  begin
    if (srst || (state != bss_pkg::ST_SOFT && state != bss_pkg::ST_RUN))
    begin
      switchesReleased <= 1'b0;
    end
    else if (state == bss_pkg::ST_RUN && retryRequest)
    begin
      switchesReleased <= 1'b0;
    end
    else if (state == bss_pkg::ST_RUN || (errAmpEnable && rampAboveOutput))
    begin
      switchesReleased <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      errAmpEnable <= 1'b0;
    end
    else
    begin
      // Short init before the amplifier drives the pin
      errAmpEnable <= (state == bss_pkg::ST_SOFT && rampValue >= RW'(bss_pkg::EA_INIT_STEPS))
                      || state == bss_pkg::ST_RUN;
    end
  end

  // Gates drop at once on enable or bias loss, not after the state moves
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      lowSideAllowed <= 1'b0;
      highSideAllowed <= 1'b0;
    end
    else
    begin
      lowSideAllowed <= switchesReleased && enableAboveTrip && porGood;
      highSideAllowed <= switchesReleased && enableAboveTrip && porGood;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      oscillatorRun <= 1'b0;
    end
    else
    begin
      oscillatorRun <= enableAboveTrip && porGood
                       && (state == bss_pkg::ST_SOFT || state == bss_pkg::ST_RUN);
    end
  end

  // Set-point current only while the trip voltage is built and read
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      setCurrentOn <= 1'b0;
    end
    else
    begin
      setCurrentOn <= (state == bss_pkg::ST_BIAS_DLY || state == bss_pkg::ST_SAMPLE);
    end
  end

  // Pull-up follows bias alone, so a released pin always charges
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      enablePullupOn <= 1'b0;
    end
    else
    begin
      enablePullupOn <= porGood;
    end
  end

  assign stateOut = state;
endmodule : bss_sequencer

//--- sim/bss_properties.sv
/*
  Port checks of the start-up sequencer.
  Assumes one clock; bound at the foot.
*/
`timescale 1ns/1ps
module bss_properties #(
  parameter int BIAS_DELAY_CYCLES = 20,
  parameter int SAMPLE_MAX_CYCLES = 40,
  parameter int STEP_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic porGood,
  input wire logic enableAboveTrip,
  input wire logic sampleCmpHigh,
  input wire logic rampAboveOutput,
  input wire logic retryRequest,
  input wire logic enablePullupOn,
  input wire logic setCurrentOn,
  input wire logic lowSideAllowed,
  input wire logic highSideAllowed,
  input wire logic oscillatorRun,
  input wire logic errAmpEnable,
  input wire logic [bss_pkg::SET_W-1:0] setPoint,
  input wire logic setPointValid,
  input wire logic [bss_pkg::RAMP_W-1:0] rampValue,
  input wire logic softStartDone,
  input bss_pkg::bss_state_e stateOut
);
  // ----------
  // Checks
  // ----------
  localparam int SAMPLE_LIM = SAMPLE_MAX_CYCLES + 2;
  int dlyCnt;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // Counter, since the delay is too long for a repetition
  always_ff @(posedge clk_sys)
  begin
    if (srst || stateOut != bss_pkg::ST_BIAS_DLY)
      dlyCnt <= 0;
    else
      dlyCnt <= dlyCnt + 1;
  end
  chk_por_idle: assert property (
    !porGood |=> stateOut == bss_pkg::ST_IDLE ##1 !highSideAllowed && !lowSideAllowed)
    else $error("por low not idle");
  chk_enable_low: assert property (
    porGood && !enableAboveTrip && stateOut != bss_pkg::ST_IDLE
    |=> stateOut == bss_pkg::ST_WAIT_EN && !oscillatorRun) else $error("enable low ignored");
  chk_delay_length: assert property (
    stateOut == bss_pkg::ST_SAMPLE && dlyCnt != 0 |-> dlyCnt == BIAS_DELAY_CYCLES + 1)
    else $error("bias delay length");
  chk_preset_phase: assert property (
    stateOut inside {bss_pkg::ST_BIAS_DLY, bss_pkg::ST_SAMPLE}
    |=> setCurrentOn && !lowSideAllowed) else $error("preset phase outputs");
  chk_sample_bound: assert property (
    $rose(stateOut == bss_pkg::ST_SAMPLE) |-> ##[0:SAMPLE_LIM] stateOut != bss_pkg::ST_SAMPLE)
    else $error("sample too long");
  chk_soft_follow: assert property (
    stateOut == bss_pkg::ST_SAMPLE && sampleCmpHigh && porGood && enableAboveTrip
    |=> stateOut == bss_pkg::ST_SOFT) else $error("soft start not begun");
  chk_done_final: assert property (
    $rose(softStartDone) |-> rampValue == 7'h41) else $error("done before final");
  chk_setpoint_hold: assert property (
    stateOut inside {bss_pkg::ST_SOFT, bss_pkg::ST_RUN}
    && $past(stateOut) inside {bss_pkg::ST_SOFT, bss_pkg::ST_RUN} |-> $stable(setPoint))
    else $error("set point moved");
  cover property (stateOut == bss_pkg::ST_RUN && softStartDone);
  cover property ($rose(stateOut == bss_pkg::ST_SAMPLE) ##1 stateOut == bss_pkg::ST_SOFT);
  cover property (retryRequest && stateOut == bss_pkg::ST_RUN);
endmodule : bss_properties

bind bss_sequencer bss_properties #(
  .BIAS_DELAY_CYCLES(BIAS_DELAY_CYCLES),
  .SAMPLE_MAX_CYCLES(SAMPLE_MAX_CYCLES),
  .STEP_CYCLES(STEP_CYCLES)
) chkU (
  .clk_sys, .srst, .porGood, .enableAboveTrip, .sampleCmpHigh, .rampAboveOutput,
  .retryRequest, .enablePullupOn, .setCurrentOn, .lowSideAllowed, .highSideAllowed,
  .oscillatorRun, .errAmpEnable, .setPoint, .setPointValid, .rampValue,
  .softStartDone, .stateOut
);

//--- sim/bss_partner.sv
/*
  System side: enable pin and the analog comparators.
  Assumes the bench sets release, trip code and pre-bias level.
*/
`timescale 1ns/1ps
module bss_partner (
  input wire logic clk_sys,
  input wire logic enRelease,
  input wire logic enablePullupOn,
  input wire logic [7:0] setPoint,
  input wire logic [7:0] trip,
  input wire logic [6:0] rampValue,
  input wire logic [6:0] preBias,
  output logic enableAboveTrip,
  output logic sampleCmpHigh,
  output logic rampAboveOutput
);
  // Pin charges slowly, so the trip lags the release
  logic [2:0] chargeCnt = 3'h0;
  logic [7:0] dacSeen = 8'h00;
  logic [6:0] rampSeen = 7'h00;
  always @(posedge clk_sys)
  begin
    if (!(enRelease && enablePullupOn))
      chargeCnt <= 3'h0;
    else if (chargeCnt != 3'h7)
      chargeCnt <= chargeCnt + 3'h1;
    dacSeen <= setPoint;
    rampSeen <= rampValue;
  end
  assign enableAboveTrip = (chargeCnt == 3'h7);
  assign sampleCmpHigh = (dacSeen >= trip);
  assign rampAboveOutput = (rampSeen > preBias);
endmodule : bss_partner

//--- sim/tb_top.sv
/*
  Self-checking bench of the start-up sequencer.
  Assumes the partner model plays the enable pin.
*/
`timescale 1ns/1ps
module tb_top;
  // ----------
  // Harness
  // ----------
  localparam int DLY = 20;
  localparam int STEP = 4;
  logic clk_sys = 1'b0, srst = 1'b1, porGood = 1'b0, retryRequest = 1'b0, enRelease = 1'b0;
  logic [7:0] trip = 8'h00, held, setPoint;
  logic [6:0] preBias = 7'h00, rampValue;
  logic enableAboveTrip, sampleCmpHigh, rampAboveOutput, enablePullupOn, setCurrentOn;
  logic lowSideAllowed, highSideAllowed, oscillatorRun, errAmpEnable, setPointValid;
  logic softStartDone;
  bss_pkg::bss_state_e stateOut;
  int err_count = 0, checked = 0, n;
  always #2.5 clk_sys = ~clk_sys;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t got %h want %h", $time, a, b); end end
  bss_sequencer #(.BIAS_DELAY_CYCLES(DLY), .SAMPLE_MAX_CYCLES(40), .STEP_CYCLES(STEP)) dut_u (
    .clk_sys, .srst, .porGood, .enableAboveTrip, .sampleCmpHigh, .rampAboveOutput,
    .retryRequest, .enablePullupOn, .setCurrentOn, .lowSideAllowed, .highSideAllowed,
    .oscillatorRun, .errAmpEnable, .setPoint, .setPointValid, .rampValue,
    .softStartDone, .stateOut
  );
  bss_partner partner_u (
    .clk_sys, .enRelease, .enablePullupOn, .setPoint, .trip, .rampValue, .preBias,
    .enableAboveTrip, .sampleCmpHigh, .rampAboveOutput
  );
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic await(input bss_pkg::bss_state_e st, input int lim);
    n = 0;
    while (stateOut !== st && n < lim)
    begin
      step(1);
      n++;
    end
    if (n >= lim)
    begin
      err_count++;
      wrap_up();
    end
  endtask : await
  task automatic t_hold_off();
    porGood = 1'b1;
    step(30);
    `CHK(stateOut, bss_pkg::ST_WAIT_EN)
    `CHK(oscillatorRun, 1'b0)
    `CHK(enablePullupOn, 1'b1)
    $display("hold_off done");
  endtask : t_hold_off
  task automatic t_start(input logic [7:0] tr, input logic [6:0] pb);
    trip = tr;
    preBias = pb;
    enRelease = 1'b1;
    await(bss_pkg::ST_BIAS_DLY, 20);
    step(1);
    `CHK(setCurrentOn, 1'b1)
    `CHK(lowSideAllowed, 1'b0)
    await(bss_pkg::ST_SAMPLE, 40);
    `CHK(n, DLY)
    await(bss_pkg::ST_SOFT, 60);
    `CHK(setPointValid, 1'b1)
    `CHK(setPoint >= tr || tr > 8'h28, 1'b1)
    `CHK(errAmpEnable, 1'b0)
    n = 0;
    while (stateOut === bss_pkg::ST_SOFT && n < 400)
    begin
      if (rampValue <= pb) `CHK(highSideAllowed, 1'b0)
      if (int'(rampValue) > int'(pb) + 2) `CHK(highSideAllowed, 1'b1)
      step(1);
      n++;
    end
    if (n >= 400)
    begin
      err_count++;
      wrap_up();
    end
    `CHK(n >= 64 * STEP, 1'b1)
    `CHK(rampValue, 7'h41)
    `CHK(errAmpEnable, 1'b1)
    step(2);
    `CHK(softStartDone, 1'b1)
    `CHK(highSideAllowed, 1'b1)
    `CHK(lowSideAllowed, 1'b1)
    `CHK(oscillatorRun, 1'b1)
    held = setPoint;
    $display("start done");
  endtask : t_start
  task automatic t_disable();
    enRelease = 1'b0;
    await(bss_pkg::ST_WAIT_EN, 20);
    step(2);
    `CHK(oscillatorRun, 1'b0)
    `CHK(highSideAllowed, 1'b0)
    $display("disable done");
  endtask : t_disable
  task automatic t_retry();
    retryRequest = 1'b1;
    step(1);
    retryRequest = 1'b0;
    await(bss_pkg::ST_SOFT, 4);
    await(bss_pkg::ST_RUN, 400);
    `CHK(setPoint, held)
    $display("retry done");
  endtask : t_retry
  task automatic t_por_drop();
    porGood = 1'b0;
    step(3);
    `CHK(stateOut, bss_pkg::ST_IDLE)
    `CHK(setPointValid, 1'b0)
    `CHK(setPoint, 8'h00)
    `CHK(highSideAllowed, 1'b0)
    `CHK(enablePullupOn, 1'b0)
    $display("por_drop done");
  endtask : t_por_drop
  initial
  begin
    step(12);
    srst = 1'b0;
    t_hold_off();
    t_start(8'h00, 7'h00);
    t_disable();
    t_start(8'h10, 7'h20);
    t_retry();
    t_disable();
    t_start(8'hc8, 7'h7f);
    t_por_drop();
    wrap_up();
  end
endmodule : tb_top
